// ### tb.sv
// self-checking bench for the transmit robbed-bit signaling inserter
`timescale 1ns/1ps
module tb;
  import trbs_pkg::*;
  logic clock;
  logic rst;
  logic clock_en;
  logic esf_mode;
  logic upper_nibble_select;
  logic cpu_cs;
  logic cpu_wr_en;
  logic cpu_rd_en;
  logic [3:0] cpu_page;
  logic [4:0] cpu_addr;
  logic [7:0] cpu_wdata;
  logic [7:0] cpu_rdata;
  logic serial_control_input;
  logic serial_frame_sync;
  logic tx_in_valid;
  logic [4:0] tx_in_frame;
  logic [4:0] tx_in_chan;
  logic [7:0] tx_in_data;
  logic tx_out_valid;
  logic [7:0] tx_out_data;
  logic [7:0] slots [32];
  int miscompares;
  int compares;

  trbs_tx_sig u_dut (.clock(clock), .rst(rst), .clock_en(clock_en), .esf_mode(esf_mode),
    .upper_nibble_select(upper_nibble_select), .cpu_cs(cpu_cs), .cpu_wr_en(cpu_wr_en),
    .cpu_rd_en(cpu_rd_en), .cpu_page(cpu_page), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .cpu_rdata(cpu_rdata), .serial_control_input(serial_control_input),
    .serial_frame_sync(serial_frame_sync), .tx_in_valid(tx_in_valid),
    .tx_in_frame(tx_in_frame), .tx_in_chan(tx_in_chan), .tx_in_data(tx_in_data),
    .tx_out_valid(tx_out_valid), .tx_out_data(tx_out_data));

  trbs_serial_src u_src (.clock(clock), .serial_control_input(serial_control_input),
    .serial_frame_sync(serial_frame_sync));

  // 4 ns clock
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic summarize();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : summarize

  // one register cycle; the read result is sampled once the taking edge has landed
  task automatic bus(input logic we, input logic [3:0] pg, input logic [4:0] ad,
                     input logic [7:0] wd, output logic [7:0] rd);
    @(posedge clock);
    cpu_cs <= 1'b1;
    cpu_wr_en <= we;
    cpu_rd_en <= ~we;
    cpu_page <= pg;
    cpu_addr <= ad;
    cpu_wdata <= wd;
    @(posedge clock);
    cpu_cs <= 1'b0;
    cpu_wr_en <= 1'b0;
    cpu_rd_en <= 1'b0;
    #1;
    rd = cpu_rdata;
  endtask : bus

  // one transmit byte; a missing valid shows as unknown so it can never match
  task automatic tx(input logic [4:0] fr, input logic [4:0] ch, input logic [7:0] d,
                    output logic [7:0] obs);
    @(posedge clock);
    tx_in_valid <= 1'b1;
    tx_in_frame <= fr;
    tx_in_chan <= ch;
    tx_in_data <= d;
    @(posedge clock);
    tx_in_valid <= 1'b0;
    #1;
    obs = (tx_out_valid === 1'b1) ? tx_out_data : 8'hxx;
  endtask : tx

  // one superframe: start byte, a plain frame, then every signaling frame of the mode
  task automatic sf(input logic [4:0] ch, input logic [3:0] nib, input logic cc);
    logic [7:0] obs;
    logic [7:0] d;
    tx(5'h01, 5'h00, 8'h55, obs);
    check(obs, 8'h55);
    tx(5'h05, ch, 8'h3C, obs);
    check(obs, 8'h3C);
    for (int i = 0; i < (esf_mode ? 4 : 2); i++) begin
      d = {7'h52, ~nib[3 - i]};
      tx(5'(6 * (i + 1)), ch, d, obs);
      check(obs, cc ? d : {7'h52, nib[3 - i]});
    end
  endtask : sf

  task automatic t_reset();
    logic [7:0] obs;
    check(cpu_rdata, 8'h00);
    check({7'h00, tx_out_valid}, 8'h00);
    bus(1'b0, 4'h7, 5'h10, 8'h00, obs);
    check(obs, 8'h00);
  endtask : t_reset

  // page boundaries, processor source, unused upper bits and unmapped places
  task automatic t_regmap();
    logic [3:0] pg [4] = '{4'h5, 4'h5, 4'h6, 4'h6};
    logic [4:0] ad [4] = '{5'h10, 5'h1F, 5'h10, 5'h17};
    logic [4:0] ch [4] = '{5'h00, 5'h0F, 5'h10, 5'h17};
    logic [3:0] nb [4] = '{4'hA, 4'h5, 4'hC, 4'h3};
    logic [7:0] obs;
    for (int k = 0; k < 4; k++) begin
      bus(1'b1, pg[k], ad[k], {4'hF, nb[k]}, obs);
      bus(1'b1, pg[k] + 4'h2, ad[k], 8'h02, obs);
      bus(1'b0, pg[k], ad[k], 8'h00, obs);
      check(obs, {4'h0, nb[k]});
      sf(ch[k], nb[k], 1'b0);
    end
    bus(1'b1, 4'h6, 5'h18, 8'hFF, obs);
    bus(1'b0, 4'h6, 5'h18, 8'h00, obs);
    check(obs, 8'h00);
    bus(1'b0, 4'h5, 5'h0F, 8'h00, obs);
    check(obs, 8'h00);
  endtask : t_regmap

  // d4 framing, clear channel, and a word changed in mid-superframe
  task automatic t_modes();
    logic [7:0] obs;
    @(posedge clock);
    esf_mode <= 1'b0;
    sf(5'h00, 4'hA, 1'b0);
    @(posedge clock);
    esf_mode <= 1'b1;
    bus(1'b1, 4'h7, 5'h10, 8'h03, obs);
    sf(5'h00, 4'hA, 1'b1);
    bus(1'b1, 4'h7, 5'h10, 8'h02, obs);
    tx(5'h01, 5'h00, 8'h00, obs);
    bus(1'b1, 4'h5, 5'h10, 8'h05, obs);
    tx(5'h06, 5'h00, 8'hA4, obs);
    check(obs, 8'hA5);
    sf(5'h00, 4'h5, 1'b0);
  endtask : t_modes

  // serial source on channels 2 and 23, both nibble halves, both framings
  task automatic t_serial(input logic upper, input logic [3:0] n1, input logic [3:0] n22);
    @(posedge clock);
    upper_nibble_select <= upper;
    esf_mode <= 1'b1;
    u_src.send_frame(slots);
    repeat (4) @(posedge clock);
    sf(5'h01, n1, 1'b0);
    sf(5'h16, n22, 1'b0);
    @(posedge clock);
    esf_mode <= 1'b0;
    sf(5'h01, n1, 1'b0);
  endtask : t_serial

  // clock enable freezes a write, channels past 24 pass, a mid-run reset clears the words
  task automatic t_enable();
    logic [7:0] obs;
    @(posedge clock);
    clock_en <= 1'b0;
    bus(1'b1, 4'h5, 5'h11, 8'h0F, obs);
    @(posedge clock);
    clock_en <= 1'b1;
    bus(1'b0, 4'h5, 5'h11, 8'h00, obs);
    check(obs, 8'h00);
    bus(1'b1, 4'h5, 5'h11, 8'h0F, obs);
    bus(1'b0, 4'h5, 5'h11, 8'h00, obs);
    check(obs, 8'h0F);
    tx(5'h06, 5'h18, 8'h00, obs);
    check(obs, 8'h00);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    bus(1'b0, 4'h5, 5'h10, 8'h00, obs);
    check(obs, 8'h00);
    check({7'h00, tx_out_valid}, 8'h00);
  endtask : t_enable

  // hang guard
  initial begin
    repeat (100000) @(posedge clock);
    miscompares++;
    summarize();
  end

  // main sequence
  initial begin
    miscompares = 0;
    compares = 0;
    rst = 1'b1;
    clock_en = 1'b1;
    esf_mode = 1'b1;
    upper_nibble_select = 1'b1;
    cpu_cs = 1'b0;
    cpu_wr_en = 1'b0;
    cpu_rd_en = 1'b0;
    cpu_page = 4'h0;
    cpu_addr = 5'h00;
    cpu_wdata = 8'h00;
    tx_in_valid = 1'b0;
    tx_in_frame = 5'h00;
    tx_in_chan = 5'h00;
    tx_in_data = 8'h00;
    // unused slots filled with ones so a miscount would show
    foreach (slots[s]) slots[s] = (s >= 24) ? 8'hFF : 8'h00;
    slots[1] = 8'h96;
    slots[22] = 8'hC3;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    #1;
    t_reset();
    t_regmap();
    t_modes();
    t_serial(1'b1, 4'h9, 4'hC);
    t_serial(1'b0, 4'h6, 4'h3);
    t_enable();
    summarize();
  end
endmodule : tb

// ### trbs_pair_buf.sv
// two-entry valid/ready buffer between the serial deserialiser and the nibble store
`timescale 1ns/1ps
module trbs_pair_buf
  import trbs_pkg::*;
#(
  parameter int WIDTH = 9,
  parameter int DEPTH = 2
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);

  if (DEPTH != 2 || WIDTH < 1) begin : g_check
    $error("trbs_pair_buf supports exactly two entries");
  end

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [WIDTH-1:0] mem_next [DEPTH];
  logic wr_ptr_reg, wr_ptr_next;
  logic rd_ptr_reg, rd_ptr_next;
  logic [1:0] count_reg, count_next;
  logic push, pop;

  // full and empty come straight from the occupancy count
  assign in_ready = (count_reg != 2'h2);
  assign out_valid = (count_reg != 2'h0);
  assign out_data = mem_reg[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // pointer and storage update
  always_comb begin
    mem_next = mem_reg;
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next = count_reg;
    if (push) begin
      mem_next[wr_ptr_reg] = in_data;
      wr_ptr_next = ~wr_ptr_reg;
    end
    if (pop) begin
      rd_ptr_next = ~rd_ptr_reg;
    end
    if (push && !pop) begin
      count_next = count_reg + 2'h1;
    end else if (pop && !push) begin
      count_next = count_reg - 2'h1;
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      mem_reg <= '{default: '0};
      wr_ptr_reg <= 1'b0;
      rd_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end else if (clock_en) begin
      mem_reg <= mem_next;
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg <= count_next;
    end
  end

endmodule : trbs_pair_buf

// ### trbs_pkg.sv
// constants shared by the t1 transmit robbed-bit signaling inserter
package trbs_pkg;

  // channel count and widths
  localparam int TRBS_CHANNELS = 24;
  localparam int TRBS_NIB_W = 4;
  localparam int TRBS_SLOT_BITS = 8;

  // processor port pages and offsets
  localparam logic [3:0] TRBS_PAGE_SIG_LO = 4'h5;
  localparam logic [3:0] TRBS_PAGE_SIG_HI = 4'h6;
  localparam logic [3:0] TRBS_PAGE_CTL_LO = 4'h7;
  localparam logic [3:0] TRBS_PAGE_CTL_HI = 4'h8;
  localparam logic [4:0] TRBS_ADDR_FIRST = 5'h10;
  localparam logic [4:0] TRBS_ADDR_LO_LAST = 5'h1F;
  localparam logic [4:0] TRBS_ADDR_HI_LAST = 5'h17;
  localparam logic [4:0] TRBS_HI_CHAN_BASE = 5'h10;

  // signaling word field positions
  localparam int TRBS_POS_A = 3;
  localparam int TRBS_POS_B = 2;
  localparam int TRBS_POS_C = 1;
  localparam int TRBS_POS_D = 0;

  // per time slot control field positions
  localparam int TRBS_CTL_SRC_POS = 1;
  localparam int TRBS_CTL_CC_POS = 0;

  // robbed bit: bit position 8 of a channel is the byte lsb
  localparam int TRBS_ROBBED_POS = 0;

  // superframe frame numbers, counted from 1
  localparam logic [4:0] TRBS_FRAME_FIRST = 5'h01;
  localparam logic [4:0] TRBS_FRAME_A = 5'h06;
  localparam logic [4:0] TRBS_FRAME_B = 5'h0C;
  localparam logic [4:0] TRBS_FRAME_C = 5'h12;
  localparam logic [4:0] TRBS_FRAME_D = 5'h18;

  // serial slot counting
  localparam logic [2:0] TRBS_LAST_BIT = 3'h7;
  localparam logic [4:0] TRBS_LAST_SLOT = 5'h1F;
  localparam logic [4:0] TRBS_ACTIVE_SLOTS = 5'h18;

  // values after reset
  localparam logic [3:0] TRBS_SIG_RESET = 4'h0;
  localparam logic [1:0] TRBS_CTL_RESET = 2'h0;
  localparam logic [7:0] TRBS_BYTE_RESET = 8'h00;

  // buffer entry: {slot index, nibble}
  typedef logic [8:0] trbs_entry_t;

endpackage : trbs_pkg

// ### trbs_serial_src.sv
// serial backplane signaling source model feeding the transmit inserter
`timescale 1ns/1ps
module trbs_serial_src
  import trbs_pkg::*;
(
  input wire logic clock,
  output logic serial_control_input,
  output logic serial_frame_sync
);
  logic last_bit;

  // quiet line until the first frame
  initial begin
    serial_control_input = 1'b0;
    serial_frame_sync = 1'b0;
    last_bit = 1'b0;
  end

  // one frame of 32 slots, msb first; the sync pulse marks bit 7 of slot 0
  task automatic send_frame(input logic [7:0] slots [32]);
    for (int s = 0; s < 32; s++) begin
      for (int b = TRBS_SLOT_BITS - 1; b >= 0; b--) begin
        @(posedge clock);
        serial_frame_sync <= (s == 0 && b == 7);
        serial_control_input <= slots[s][b];
        last_bit = slots[s][b];
      end
    end
    // line left with the inverse so a stale bit never reads as data
    @(posedge clock);
    serial_frame_sync <= 1'b0;
    serial_control_input <= ~last_bit;
  endtask : send_frame
endmodule : trbs_serial_src

// ### trbs_tx_sig.sv
// t1 transmit robbed-bit signaling inserter with processor and serial sources
//
// Summary of operation
// R1: channels 1-16 at 0x10-0x1F of page one, 17-24 at 0x10-0x17 of page two.
// R2: source bit high takes the channel's signaling from its processor-written word.
// R3: word bit 3 is A, sent in bit 8 of frame 6; bits 7-4 unused.
// R4: word bit 2 is B, sent in bit 8 of frame 12.
// R5: word bit 1 is C, sent in frame 18 under ESF; ignored in D4.
// R6: word bit 0 is D, sent in frame 24 under ESF; ignored in D4.
// R7: stored signaling is inserted only where the channel has signaling enabled.
// R8: source bit low takes signaling from the channel's serial backplane slot.
// R9: upper nibble select one uses serial slot bits 7-4 as A-D.
// R10: upper nibble select zero uses serial slot bits 3-0 as A-D.
// R11: ESF sends the four serial bits in frames 6, 12, 18 and 24.
// R12: D4 sends only serial A and B in frames 6 and 12.
// R13: clear channel high inserts no robbed bit; low inserts every sixth frame.
// R14: signaling is captured once per superframe so all frames stay consistent.
`timescale 1ns/1ps
module trbs_tx_sig
  import trbs_pkg::*;
#(
  parameter int CHANNELS = TRBS_CHANNELS
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic clock_en,
  input wire logic esf_mode,
  input wire logic upper_nibble_select,
  input wire logic cpu_cs,
  input wire logic cpu_wr_en,
  input wire logic cpu_rd_en,
  input wire logic [3:0] cpu_page,
  input wire logic [4:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  output logic [7:0] cpu_rdata,
  input wire logic serial_control_input,
  input wire logic serial_frame_sync,
  input wire logic tx_in_valid,
  input wire logic [4:0] tx_in_frame,
  input wire logic [4:0] tx_in_chan,
  input wire logic [7:0] tx_in_data,
  output logic tx_out_valid,
  output logic [7:0] tx_out_data
);

  if (CHANNELS != TRBS_CHANNELS) begin : g_check
    $error("trbs_tx_sig maps exactly 24 channels over two pages");
  end

  // page/offset decode: {hit, control page, channel index}
  function automatic logic [6:0] trbs_decode(input logic [3:0] page, input logic [4:0] addr);
    logic [6:0] res;
    res = 7'h00;
    if ((page == TRBS_PAGE_SIG_LO || page == TRBS_PAGE_CTL_LO) &&
        addr >= TRBS_ADDR_FIRST && addr <= TRBS_ADDR_LO_LAST) begin
      res = {1'b1, page == TRBS_PAGE_CTL_LO, addr - TRBS_ADDR_FIRST}; // R1
    end else if ((page == TRBS_PAGE_SIG_HI || page == TRBS_PAGE_CTL_HI) &&
        addr >= TRBS_ADDR_FIRST && addr <= TRBS_ADDR_HI_LAST) begin
      res = {1'b1, page == TRBS_PAGE_CTL_HI, addr}; // R1
    end
    return res;
  endfunction : trbs_decode

  // robbed bit for a frame: {insert, value}
  function automatic logic [1:0] trbs_pick(input logic [3:0] nib, input logic [4:0] frame,
                                           input logic esf);
    logic [1:0] res;
    res = 2'h0;
    if (frame == TRBS_FRAME_A) begin
      res = {1'b1, nib[TRBS_POS_A]}; // R3
    end else if (frame == TRBS_FRAME_B) begin
      res = {1'b1, nib[TRBS_POS_B]}; // R4
    end else if (esf && frame == TRBS_FRAME_C) begin
      res = {1'b1, nib[TRBS_POS_C]}; // R5
    end else if (esf && frame == TRBS_FRAME_D) begin
      res = {1'b1, nib[TRBS_POS_D]}; // R6
    end
    return res;
  endfunction : trbs_pick

  // register file and per-channel state
  logic [3:0] cpu_sig_reg [TRBS_CHANNELS];
  logic [3:0] cpu_sig_next [TRBS_CHANNELS];
  logic [1:0] ctl_reg [TRBS_CHANNELS];
  logic [1:0] ctl_next [TRBS_CHANNELS];
  logic [3:0] ser_sig_reg [TRBS_CHANNELS];
  logic [3:0] ser_sig_next [TRBS_CHANNELS];
  logic [3:0] sf_sig_reg [TRBS_CHANNELS];
  logic [3:0] sf_sig_next [TRBS_CHANNELS];
  logic [7:0] cpu_rdata_next;
  logic [6:0] dec;
  logic [4:0] dec_idx;

  // serial input path
  logic scin_s1_reg, scin_s2_reg, fs_s1_reg, fs_s2_reg, fs_d_reg;
  logic [6:0] shift_reg, shift_next;
  logic [2:0] bit_cnt_reg, bit_cnt_next;
  logic [4:0] slot_reg, slot_next;
  logic deser_valid_reg, deser_valid_next;
  trbs_entry_t deser_data_reg, deser_data_next;
  logic fs_rise, byte_done, deser_ready;
  logic [7:0] slot_byte;
  logic buf_out_valid, buf_out_ready;
  trbs_entry_t buf_out_data;

  // transmit path
  logic tx_out_valid_next;
  logic [7:0] tx_out_data_next;
  logic capture_now, chan_ok;
  logic [3:0] cur_nib;
  logic [1:0] cur_ctl;
  logic [1:0] pick;

  assign dec = trbs_decode(cpu_page, cpu_addr);
  assign dec_idx = dec[4:0];
  assign chan_ok = (tx_in_chan < TRBS_ACTIVE_SLOTS);
  assign cur_nib = chan_ok ? sf_sig_reg[tx_in_chan] : TRBS_SIG_RESET;
  assign cur_ctl = chan_ok ? ctl_reg[tx_in_chan] : TRBS_CTL_RESET;
  // capture on the first channel of frame one, the superframe boundary
  assign capture_now = tx_in_valid && tx_in_frame == TRBS_FRAME_FIRST && tx_in_chan == 5'h00;

  // processor port writes and registered read data
  always_comb begin
    cpu_sig_next = cpu_sig_reg;
    ctl_next = ctl_reg;
    cpu_rdata_next = cpu_rdata;
    if (cpu_cs && cpu_wr_en && dec[6]) begin
      if (dec[5]) begin
        ctl_next[dec_idx] = cpu_wdata[1:0];
      end else begin
        cpu_sig_next[dec_idx] = cpu_wdata[3:0]; // R1
      end
    end
    if (cpu_cs && cpu_rd_en) begin
      // unused bits and unmapped offsets read as zero
      if (!dec[6]) begin
        cpu_rdata_next = TRBS_BYTE_RESET;
      end else if (dec[5]) begin
        cpu_rdata_next = {6'h00, ctl_reg[dec_idx]};
      end else begin
        cpu_rdata_next = {4'h0, cpu_sig_reg[dec_idx]}; // R3
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      cpu_sig_reg <= '{default: TRBS_SIG_RESET};
      ctl_reg <= '{default: TRBS_CTL_RESET};
      cpu_rdata <= TRBS_BYTE_RESET;
    end else if (clock_en) begin
      cpu_sig_reg <= cpu_sig_next;
      ctl_reg <= ctl_next;
      cpu_rdata <= cpu_rdata_next;
    end
  end

  // pin synchronisers; only the second stage and later are read
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scin_s1_reg <= 1'b0;
      scin_s2_reg <= 1'b0;
      fs_s1_reg <= 1'b0;
      fs_s2_reg <= 1'b0;
      fs_d_reg <= 1'b0;
    end else if (clock_en) begin
      scin_s1_reg <= serial_control_input;
      scin_s2_reg <= scin_s1_reg;
      fs_s1_reg <= serial_frame_sync;
      fs_s2_reg <= fs_s1_reg;
      fs_d_reg <= fs_s2_reg;
    end
  end

  assign fs_rise = fs_s2_reg && !fs_d_reg;
  assign slot_byte = {shift_reg, scin_s2_reg};
  assign byte_done = !fs_rise && bit_cnt_reg == TRBS_LAST_BIT;

  // deserialiser: msb first, eight bits a slot, slot 0 begins at the sync edge
  always_comb begin
    shift_next = {shift_reg[5:0], scin_s2_reg};
    bit_cnt_next = bit_cnt_reg + 3'h1;
    slot_next = slot_reg;
    deser_data_next = deser_data_reg;
    deser_valid_next = deser_valid_reg && !deser_ready;
    if (fs_rise) begin
      shift_next = {6'h00, scin_s2_reg};
      bit_cnt_next = 3'h1;
      slot_next = 5'h00;
    end else if (byte_done) begin
      if (slot_reg != TRBS_LAST_SLOT) begin
        slot_next = slot_reg + 5'h01;
      end
      if (slot_reg < TRBS_ACTIVE_SLOTS) begin // R8
        // a new slot wins over the handshake clearing the old one
        deser_valid_next = 1'b1;
        deser_data_next = {slot_reg, upper_nibble_select ? slot_byte[7:4] // R9
                                                         : slot_byte[3:0]}; // R10
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      shift_reg <= 7'h00;
      bit_cnt_reg <= 3'h0;
      slot_reg <= TRBS_LAST_SLOT;
      deser_valid_reg <= 1'b0;
      deser_data_reg <= '0;
    end else if (clock_en) begin
      shift_reg <= shift_next;
      bit_cnt_reg <= bit_cnt_next;
      slot_reg <= slot_next;
      deser_valid_reg <= deser_valid_next;
      deser_data_reg <= deser_data_next;
    end
  end

  // the store stalls in the capture cycle, so the buffer absorbs that slot
  assign buf_out_ready = !capture_now;

  trbs_pair_buf #(
    .WIDTH($bits(trbs_entry_t)),
    .DEPTH(2)
  ) u_buf (
    .clock(clock),
    .rst(rst),
    .clock_en(clock_en),
    .in_valid(deser_valid_reg),
    .in_ready(deser_ready),
    .in_data(deser_data_reg),
    .out_valid(buf_out_valid),
    .out_ready(buf_out_ready),
    .out_data(buf_out_data)
  );

  // serial store and superframe capture
  always_comb begin
    ser_sig_next = ser_sig_reg;
    sf_sig_next = sf_sig_reg;
    if (buf_out_valid && buf_out_ready) begin
      ser_sig_next[buf_out_data[8:4]] = buf_out_data[3:0]; // R8
    end
    if (capture_now) begin
      for (int i = 0; i < TRBS_CHANNELS; i++) begin
        // one snapshot a superframe keeps a, b, c, d coherent
        sf_sig_next[i] = ctl_reg[i][TRBS_CTL_SRC_POS] ? cpu_sig_reg[i] // R2 R14
                                                      : ser_sig_reg[i]; // R8 R14
      end
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ser_sig_reg <= '{default: TRBS_SIG_RESET};
      sf_sig_reg <= '{default: TRBS_SIG_RESET};
    end else if (clock_en) begin
      ser_sig_reg <= ser_sig_next;
      sf_sig_reg <= sf_sig_next;
    end
  end

  // robbed-bit insertion, one registered stage
  assign pick = trbs_pick(cur_nib, tx_in_frame, esf_mode); // R11 R12
  always_comb begin
    tx_out_valid_next = tx_in_valid;
    tx_out_data_next = tx_in_data;
    if (tx_in_valid && chan_ok && pick[1] && !cur_ctl[TRBS_CTL_CC_POS]) begin // R7 R13
      tx_out_data_next[TRBS_ROBBED_POS] = pick[0];
    end
  end

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tx_out_valid <= 1'b0;
      tx_out_data <= TRBS_BYTE_RESET;
    end else if (clock_en) begin
      tx_out_valid <= tx_out_valid_next;
      tx_out_data <= tx_out_data_next;
    end
  end

  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_low_page_map: assert property (clock_en && cpu_cs && cpu_wr_en // R1
    && cpu_page == TRBS_PAGE_SIG_LO && cpu_addr == TRBS_ADDR_FIRST
    |=> cpu_sig_reg[0] == $past(cpu_wdata[3:0]))
    else $error("page one offset 0x10 did not reach channel 1");

  a_high_page_map: assert property (clock_en && cpu_cs && cpu_wr_en // R1
    && cpu_page == TRBS_PAGE_SIG_HI && cpu_addr == TRBS_ADDR_HI_LAST
    |=> cpu_sig_reg[23] == $past(cpu_wdata[3:0]))
    else $error("page two offset 0x17 did not reach channel 24");

  a_clear_chan_pass: assert property (clock_en && tx_in_valid // R13
    && cur_ctl[TRBS_CTL_CC_POS] |=> tx_out_data == $past(tx_in_data) && tx_out_valid)
    else $error("clear channel byte was altered");

  a_frame_a_bit: assert property (clock_en && tx_in_valid && chan_ok // R3
    && !cur_ctl[TRBS_CTL_CC_POS] && tx_in_frame == TRBS_FRAME_A
    |=> tx_out_data[0] == $past(cur_nib[3]))
    else $error("frame 6 robbed bit is not A");

  a_frame_b_bit: assert property (clock_en && tx_in_valid && chan_ok // R4
    && !cur_ctl[TRBS_CTL_CC_POS] && tx_in_frame == TRBS_FRAME_B
    |=> tx_out_data[0] == $past(cur_nib[2]))
    else $error("frame 12 robbed bit is not B");

  a_esf_c_bit: assert property (clock_en && tx_in_valid && chan_ok && esf_mode // R5 R11
    && !cur_ctl[TRBS_CTL_CC_POS] && tx_in_frame == TRBS_FRAME_C
    |=> tx_out_data[0] == $past(cur_nib[1]))
    else $error("esf frame 18 robbed bit is not C");

  a_esf_d_bit: assert property (clock_en && tx_in_valid && chan_ok && esf_mode // R6 R11
    && !cur_ctl[TRBS_CTL_CC_POS] && tx_in_frame == TRBS_FRAME_D
    |=> tx_out_data[0] == $past(cur_nib[0]))
    else $error("esf frame 24 robbed bit is not D");

  a_d4_other_frames: assert property (clock_en && tx_in_valid && !esf_mode // R12 R7
    && tx_in_frame != TRBS_FRAME_A && tx_in_frame != TRBS_FRAME_B
    |=> tx_out_data == $past(tx_in_data))
    else $error("d4 byte altered outside frames 6 and 12");

  a_capture_source: assert property (clock_en && capture_now // R2 R8 R14
    |=> sf_sig_reg[0] == ($past(ctl_reg[0][1]) ? $past(cpu_sig_reg[0])
                                              : $past(ser_sig_reg[0])))
    else $error("superframe snapshot took the wrong source");

  a_nibble_select: assert property (clock_en && byte_done && slot_reg == 5'h00 // R9 R10
    |=> deser_valid_reg && deser_data_reg[3:0] == ($past(upper_nibble_select)
        ? $past(slot_byte[7:4]) : $past(slot_byte[3:0])) && deser_data_reg[8:4] == 5'h00)
    else $error("serial slot nibble chosen wrongly");

  c_cpu_source_capture: cover property (clock_en && capture_now && ctl_reg[0][1]);
  c_serial_store: cover property (clock_en && buf_out_valid && buf_out_ready);
  c_buffer_stall: cover property (clock_en && buf_out_valid && !buf_out_ready);
  c_esf_d_insert: cover property (clock_en && tx_in_valid && esf_mode && pick[1]
    && tx_in_frame == TRBS_FRAME_D);

endmodule : trbs_tx_sig
